// File: mia_pkg.sv
// Functional notes
// [R1] Eleven maskable request sources: four port lines and seven internal.
// [R2] The serial buffer empty request skips masks and flags and goes to the cpu.
// [R3] The cpu interrupt is high only while a stored flag is set and the global enable is set.
// [R4] A flag is set only by a rising edge of its request while its mask bit is one.
// [R5] Reset clears all masks and the global enable.
// [R6] Reading a flag register returns its contents and then clears all its flags.
// [R7] Writing one to a flag bit clears it; writing zero leaves it.
// [R8] Software orders servicing and keeps a copy of a flag read with several requests.
// [R9] Storing a request depends on its mask and, for peripheral requests, on auto-send, not on the global enable.
// [R10] A request during servicing is held and raises the interrupt again afterwards.
// [R11] Entering halt sets the global enable automatically.
// [R12] While auto-send is high the halt enable is suppressed and peripheral requests are off.
// [R13] First flag register holds port lines 0 to 3 in bits 0 to 3, reset zero.
// [R14] Second flag register: bit3 1 Hz, bit2 fast tick, bit1 nvm done, bit0 conversion done.
// [R15] Third flag register: bit2 supply check, bit1 counter zero, bit0 counter match, bit3 unused.
// [R16] Three mask registers mirror the flag layout, reset zero, and gate storing.
// [R17] A new qualifying edge in the same cycle as a clear keeps the flag set.
package mia_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 4;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_FLAGS_PORT_A = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS_TIMEBASE = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS_COUNTER = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_MASK_PORT_A = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_MASK_TIMEBASE = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_MASK_COUNTER = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_SYS_CONTROL = 4'h6;

	// ----------------------------------------------------------------
	// fields
	// ----------------------------------------------------------------
	localparam int BIT_ONE_HERTZ = 3;
	localparam int BIT_FAST_TICK = 2;
	localparam int BIT_NVM_DONE = 1;
	localparam int BIT_CONV_DONE = 0;
	localparam int BIT_SUPPLY_DONE = 2;
	localparam int BIT_COUNTER_ZERO = 1;
	localparam int BIT_COUNTER_MATCH = 0;
	localparam int BIT_GLOBAL_EN = 0;
	localparam logic [DATA_W-1:0] COUNTER_REG_USED = 4'h7;
	localparam logic [DATA_W-1:0] RESET_VALUE = 4'h0;

endpackage : mia_pkg

// File: mia_irq_aggregator.sv
`timescale 1ns/10ps
module mia_irq_aggregator (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [mia_pkg::ADDR_W-1:0] regAddr,
	input wire logic [mia_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [mia_pkg::DATA_W-1:0] regRdData,
	input wire logic [3:0] inputPortFirst,
	input wire logic oneHertzTick,
	input wire logic fastTick,
	input wire logic nvmWriteDone,
	input wire logic conversionDone,
	input wire logic supplyCheckDone,
	input wire logic counterZero,
	input wire logic counterMatch,
	input wire logic serialBufferEmptyRequest,
	input wire logic serialBufferAutoSend,
	input wire logic haltEntry,
	output logic cpuIrq,
	output logic cpuSerialIrq,
	output logic globalIrqEnable
);
	import mia_pkg::*;

	// ----------------------------------------------------------------
	// request synchronisers and edge detect
	// ----------------------------------------------------------------
	// request vector: [3:0] port lines, [7:4] timebase, [11:8] counter
	logic [11:0] reqAsync;
	logic [11:0] reqMeta;
	logic [11:0] reqSync;
	logic [11:0] reqLast;
	logic [1:0] sbeMeta;
	logic [2:0] haltSync;
	logic [1:0] autoSync;

	assign reqAsync = {1'b0, supplyCheckDone, counterZero, counterMatch,
		oneHertzTick, fastTick, nvmWriteDone, conversionDone,
		inputPortFirst}; // [R1] [R13] [R14] [R15]

	// pins cross in through two flops; only the second is read
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reqMeta <= 12'h000;
			reqSync <= 12'h000;
			reqLast <= 12'h000;
			sbeMeta <= 2'b00;
			haltSync <= 3'b000;
			autoSync <= 2'b00;
		end else begin
			reqMeta <= reqAsync;
			reqSync <= reqMeta;
			reqLast <= reqSync;
			sbeMeta <= {sbeMeta[0], serialBufferEmptyRequest};
			haltSync <= {haltSync[1:0], haltEntry};
			autoSync <= {autoSync[0], serialBufferAutoSend};
		end
	end

	wire [11:0] reqRise = reqSync & ~reqLast;
	wire haltRise = haltSync[1] & ~haltSync[2];
	wire autoSend = autoSync[1];

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	logic [11:0] flags;
	logic [11:0] masks;
	logic globalEn;

	wire selFlagA = regAddr == ADDR_FLAGS_PORT_A;
	wire selFlagB = regAddr == ADDR_FLAGS_TIMEBASE;
	wire selFlagC = regAddr == ADDR_FLAGS_COUNTER;
	wire selMaskA = regAddr == ADDR_MASK_PORT_A;
	wire selMaskB = regAddr == ADDR_MASK_TIMEBASE;
	wire selMaskC = regAddr == ADDR_MASK_COUNTER;
	wire selSys = regAddr == ADDR_SYS_CONTROL;
	wire [11:0] flagSel = {{4{selFlagC}}, {4{selFlagB}}, {4{selFlagA}}};
	wire [11:0] wrOnes = {3{regWrData}};
	wire [11:0] usedBits = {COUNTER_REG_USED, 4'hf, 4'hf};

	// clear-on-read wipes the whole addressed register
	wire [11:0] readClear = regRead ? flagSel : 12'h000; // [R6]
	wire [11:0] writeClear = regWrite ? (flagSel & wrOnes) : 12'h000; // [R7]
	// auto-send shuts peripheral requests out; port lines stay live
	wire [11:0] sourceGate = autoSend ? 12'h00f : 12'hfff; // [R12]
	// set wins over clear so a coincident edge is kept
	wire [11:0] setMask = reqRise & masks & sourceGate & usedBits; // [R4] [R9]
	wire [11:0] next_flags = (flags & ~(readClear | writeClear))
		| setMask; // [R17] [R10]

	wire [11:0] next_masks = regWrite ? {
		selMaskC ? (regWrData & COUNTER_REG_USED) : masks[11:8],
		selMaskB ? regWrData : masks[7:4],
		selMaskA ? regWrData : masks[3:0]} : masks; // [R16]

	// halt turns the enable on, unless auto-send holds it off
	wire haltSet = haltRise & ~autoSend; // [R11] [R12]
	wire next_globalEn = haltSet ? 1'b1 :
		(regWrite && selSys) ? regWrData[BIT_GLOBAL_EN] : globalEn;

	wire [DATA_W-1:0] sysRead = {3'b000, globalEn};
	wire [DATA_W-1:0] next_rd =
		selFlagA ? flags[3:0] :
		selFlagB ? flags[7:4] :
		selFlagC ? flags[11:8] :
		selMaskA ? masks[3:0] :
		selMaskB ? masks[7:4] :
		selMaskC ? masks[11:8] :
		selSys ? sysRead : RESET_VALUE;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags <= 12'h000; // [R13]
			masks <= 12'h000; // [R5]
			globalEn <= 1'b0; // [R5]
			regRdData <= RESET_VALUE;
		end else begin
			flags <= next_flags;
			masks <= next_masks;
			globalEn <= next_globalEn;
			regRdData <= regRead ? next_rd : RESET_VALUE;
		end
	end

	// ----------------------------------------------------------------
	// cpu outputs
	// ----------------------------------------------------------------
	// no priority between flags: software sorts it out
	assign cpuIrq = (|flags) & globalEn & ~autoSend; // [R3] [R12]
	assign cpuSerialIrq = sbeMeta[1]; // [R2]
	assign globalIrqEnable = globalEn;

endmodule : mia_irq_aggregator

// File: mia_src_model.sv
`timescale 1ns/10ps
module mia_src_model (
	input wire logic sys_clk,
	input wire logic [10:0] fire,
	output logic [10:0] src
);
	logic [10:0] d1 = '0;
	logic [10:0] d2 = '0;
	// stretched to 3 cycles so the input synchroniser cannot miss it
	always_ff @(posedge sys_clk) begin
		d1 <= fire;
		d2 <= d1;
	end
	assign src = fire | d1 | d2;
endmodule : mia_src_model

// File: mia_irq_aggregator_assertions.sv
`timescale 1ns/10ps
module mia_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] regAddr,
	input wire logic [3:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [3:0] regRdData,
	input wire logic serialBufferEmptyRequest,
	input wire logic serialBufferAutoSend,
	input wire logic haltEntry,
	input wire logic cpuIrq,
	input wire logic cpuSerialIrq,
	input wire logic globalIrqEnable
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_rd; !$past(regRead) |-> regRdData == 4'h0; endproperty
	a_rd: assert property (p_rd) else $error("read data not idle");
	property p_en; cpuIrq |-> globalIrqEnable; endproperty
	a_en: assert property (p_en) else $error("irq without enable");
	property p_auto; serialBufferAutoSend [*4] |-> !cpuIrq; endproperty
	a_auto: assert property (p_auto) else $error("irq in auto send");
	property p_ser; !$past(rst) && !$past(rst, 2) |->
		cpuSerialIrq == $past(serialBufferEmptyRequest, 2); endproperty
	a_ser: assert property (p_ser) else $error("serial irq path");
	property p_halt; $rose(haltEntry) && !serialBufferAutoSend ##1
		!serialBufferAutoSend [*3] |-> ##[1:4] globalIrqEnable; endproperty
	a_halt: assert property (p_halt) else $error("halt enable");
	property p_rst; $past(rst) |-> !globalIrqEnable && !cpuIrq; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_wen; regWrite && regAddr == 4'h6 |=>
		globalIrqEnable == $past(regWrData[0]); endproperty
	a_wen: assert property (p_wen) else $error("enable write");
	property p_msk; regWrite && regAddr inside {4'h3, 4'h4} ##2 regRead &&
		regAddr == $past(regAddr, 2) |=> regRdData == $past(regWrData, 3);
	endproperty
	a_msk: assert property (p_msk) else $error("mask readback");
endmodule : mia_chk
bind mia_irq_aggregator mia_chk u_mia_chk (.sys_clk(sys_clk), .rst(rst),
	.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
	.regRead(regRead), .regRdData(regRdData), .cpuIrq(cpuIrq),
	.serialBufferEmptyRequest(serialBufferEmptyRequest),
	.serialBufferAutoSend(serialBufferAutoSend), .haltEntry(haltEntry),
	.cpuSerialIrq(cpuSerialIrq), .globalIrqEnable(globalIrqEnable));

// File: mia_irq_aggregator_tb.sv
`timescale 1ns/10ps
module mia_irq_aggregator_tb;
	logic sysClk = 0, rst = 1, wrS = 0, rdS = 0, sbe = 0, autoS = 0, halt = 0;
	logic [3:0] addr = '0, wdat = '0, rdat, m[3], f[3];
	logic cpuIrq, serIrq, gEn;
	logic [10:0] fire = '0, src, fv;
	int errors = 0, n_compared = 0, seed = 65;
	always #5 sysClk = ~sysClk;
	mia_src_model u_mia_src_model (.sys_clk(sysClk), .fire(fire), .src(src));
	mia_irq_aggregator u_mia_irq_aggregator (.sys_clk(sysClk), .rst(rst),
		.regAddr(addr), .regWrData(wdat), .regWrite(wrS), .regRead(rdS),
		.regRdData(rdat), .inputPortFirst(src[3:0]), .oneHertzTick(src[7]),
		.fastTick(src[6]), .nvmWriteDone(src[5]), .conversionDone(src[4]),
		.supplyCheckDone(src[10]), .counterZero(src[9]),
		.counterMatch(src[8]), .serialBufferEmptyRequest(sbe),
		.serialBufferAutoSend(autoS), .haltEntry(halt), .cpuIrq(cpuIrq),
		.cpuSerialIrq(serIrq), .globalIrqEnable(gEn));
	task automatic chk(input logic [3:0] e, input logic [3:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [3:0] d);
		@(posedge sysClk) {wrS, addr, wdat} <= {1'b1, a, d};
		@(posedge sysClk) wrS <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [3:0] e);
		@(posedge sysClk) {rdS, addr} <= {1'b1, a};
		@(posedge sysClk) rdS <= 1'b0;
		#1 chk(e, rdat);
	endtask : rd
	task automatic pulse(input logic [10:0] v, input logic h);
		@(posedge sysClk) {fire, halt} <= {v, h};
		@(posedge sysClk) {fire, halt} <= '0;
		repeat (6) @(posedge sysClk);
		#1;
	endtask : pulse
	// pending bits of one flag register, given the source word and mask
	function automatic logic [3:0] expFlags(input logic [10:0] v,
		input int i, input logic [3:0] msk);
		return 4'(v >> (4 * i)) & msk;
	endfunction : expFlags
	task automatic results;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	initial begin
		repeat (16) @(posedge sysClk);
		rst <= 1'b0;
		for (int a = 0; a < 8; a++) rd(4'(a), 4'h0);
		pulse(11'h7ff, 1'b0);
		for (int i = 0; i < 3; i++) rd(4'(i), 4'h0);
		for (int k = 0; k < 6; k++) begin
			wr(4'h6, 4'h0);
			fv = 11'($random(seed));
			for (int i = 0; i < 3; i++) begin
				m[i] = 4'($random(seed));
				wr(4'(i + 3), m[i]);
				m[i] = m[i] & (i == 2 ? 4'h7 : 4'hf);
				rd(4'(i + 3), m[i]);
				// software copy of what should be pending
				f[i] = expFlags(fv, i, m[i]);
			end
			pulse(fv, 1'b0);
			chk(4'h0, {3'h0, cpuIrq});
			wr(4'h6, 4'h1);
			#1 chk({3'h0, |{f[0], f[1], f[2]}}, {3'h0, cpuIrq});
			rd(4'h0, f[0]);
			rd(4'h0, 4'h0);
			wr(4'h1, 4'h5);
			rd(4'h1, f[1] & 4'ha);
			rd(4'h2, f[2]);
		end
		wr(4'h6, 4'h0);
		pulse(11'h0, 1'b1);
		chk(4'h1, {3'h0, gEn});
		wr(4'h3, 4'hf);
		wr(4'h4, 4'hf);
		autoS <= 1'b1;
		wr(4'h6, 4'h0);
		pulse(11'h0ff, 1'b1);
		chk(4'h0, {3'h0, gEn});
		rd(4'h1, 4'h0);
		rd(4'h0, 4'hf);
		@(posedge sysClk) sbe <= 1'b1;
		repeat (3) @(posedge sysClk);
		#1 chk(4'h1, {3'h0, serIrq});
		results();
	end
	initial begin
		repeat (20000) @(posedge sysClk);
		errors++;
		results();
	end
endmodule : mia_irq_aggregator_tb
